// file: rtl/mhbi_pkg.sv
// Shared constants of the modem host bus interface
package mhbi_pkg;
  localparam int CLK_MHZ = 200;
  localparam int ISA_STROBE_NS = 100;
  localparam int ISA_STROBE_CYC = (ISA_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int MASTER_ABORT_CYC = 5;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [2:0] REG_INT_STATUS = 3'h5;
  localparam logic [2:0] REG_INT_MASK = 3'h7;
  localparam logic [5:0] CFG_ID_DW = 6'h00;
  localparam logic [5:0] CFG_CMDSTAT_DW = 6'h01;
  localparam int SERR_EN_BIT = 31;
  localparam logic [31:0] CMDSTAT_RST = 32'h0000_0000;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [31:0] PCI_BASE_DEF = 32'h0000_1000;
  localparam int PCI_SPAN_BITS = 5;
endpackage

// file: rtl/mhbi_if.sv
// Pin-level carrier joining the device end and the host end
`timescale 1ns/1ps
interface mhbi_if;
  logic [7:0] isa_h_data, isa_d_data;
  logic isa_h_oe, isa_d_oe;
  logic [3:0] host_data_low_nibble, host_data_high_nibble;
  logic [2:0] host_offset_address;
  logic host_write_strobe_n, host_read_strobe_n, port_select_n, irq;
  logic [31:0] ad_h, ad_d, ad;
  logic ad_h_oe, ad_d_oe;
  logic [3:0] cbe_n;
  logic par_h, par_d, par_h_oe, par_d_oe, par;
  logic frame_n, irdy_n, idsel;
  logic trdy_d_n, devsel_d_n, stop_d_n, ctl_d_oe;
  logic trdy_n, devsel_n, stop_n;
  logic perr_d_n, perr_d_oe, perr_n, serr_d_oe, serr_n, int_n, pme_n;
  // Undriven shared lines read as pulled high
  always_comb begin
    {host_data_high_nibble, host_data_low_nibble} = isa_d_oe ? isa_d_data : (isa_h_oe ? isa_h_data : 8'hFF);
    ad = ad_d_oe ? ad_d : (ad_h_oe ? ad_h : 32'hFFFF_FFFF);
    par = par_d_oe ? par_d : (par_h_oe ? par_h : 1'b1);
    trdy_n = ctl_d_oe ? trdy_d_n : 1'b1;
    devsel_n = ctl_d_oe ? devsel_d_n : 1'b1;
    stop_n = ctl_d_oe ? stop_d_n : 1'b1;
    perr_n = perr_d_oe ? perr_d_n : 1'b1;
    serr_n = ~serr_d_oe;
  end
  modport dev_mp(input host_data_low_nibble, host_data_high_nibble, host_offset_address, host_write_strobe_n,
    host_read_strobe_n, port_select_n, ad, cbe_n, par, frame_n, irdy_n, idsel,
    output isa_d_data, isa_d_oe, irq, ad_d, ad_d_oe, par_d, par_d_oe, trdy_d_n, devsel_d_n, stop_d_n, ctl_d_oe,
    perr_d_n, perr_d_oe, serr_d_oe, int_n, pme_n);
  modport host_mp(input host_data_low_nibble, host_data_high_nibble, irq, ad, par, trdy_n, devsel_n, stop_n,
    perr_n, serr_n, int_n, pme_n,
    output isa_h_data, isa_h_oe, host_offset_address, host_write_strobe_n, host_read_strobe_n, port_select_n,
    ad_h, ad_h_oe, cbe_n, par_h, par_h_oe, frame_n, irdy_n, idsel);
endinterface

// file: rtl/mhbi_dev.sv
// Device end: ISA-style byte port and PCI single-phase target
`timescale 1ns/1ps
module mhbi_dev #(
  parameter logic [31:0] PCI_BASE = mhbi_pkg::PCI_BASE_DEF,
  parameter logic [31:0] ID_WORD = 32'h0001_0001 // Arbitrary identity value
) (
  input wire logic clock,
  input wire logic rst_b,
  mhbi_if.dev_mp bus,
  input wire logic bus_type_select,
  input wire logic [7:0] event_set,
  input wire logic pme_request,
  input wire logic power_off_request,
  output logic power_off_out,
  output logic int_pending
);
  import mhbi_pkg::*;

  typedef enum logic [1:0] {P_IDLE = 2'b00, P_DATA = 2'b01, P_DRAIN = 2'b10, P_TURN = 2'b11} mhbi_pst_t;

  typedef struct packed {
    logic [7:0][7:0] regs;
    logic [31:0] cmdstat;
    logic wr_prev;
    logic isa_oe;
    logic [7:0] isa_dout;
    logic irq;
    logic int_n;
    logic pme_n;
    logic power_off;
    logic pend;
    mhbi_pst_t pst;
    logic frame_prev;
    logic is_write;
    logic is_cfg;
    logic [5:0] dw;
    logic [31:0] ad_o;
    logic ad_oe;
    logic par_o;
    logic par_oe;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic ctl_oe;
    logic addr_par;
    logic addr_chk;
    logic data_par;
    logic data_chk;
    logic perr_n;
    logic perr_oe;
    logic serr_oe;
  } mhbi_dev_t;

  mhbi_dev_t s_r, s_nxt;
  logic pci_mode;
  logic [7:0] isa_din;
  logic addr_phase, hit_io, hit_cfg, done;
  logic [3:0] cmd;

  function automatic logic [7:0] read_reg(input mhbi_dev_t s, input logic [2:0] idx);
    read_reg = s.regs[idx];
  endfunction

  always_comb begin
    s_nxt = s_r;
    pci_mode = bus_type_select;
    isa_din = {bus.host_data_high_nibble, bus.host_data_low_nibble};
    cmd = bus.cbe_n;
    addr_phase = pci_mode && s_r.pst == P_IDLE && !bus.frame_n && s_r.frame_prev;
    // Own window only; anything outside stays silent so a master abort can happen
    hit_io = (cmd == CMD_IO_RD || cmd == CMD_IO_WR || cmd == CMD_MEM_RD || cmd == CMD_MEM_WR)
      && bus.ad[31:PCI_SPAN_BITS] == PCI_BASE[31:PCI_SPAN_BITS];
    hit_cfg = bus.idsel && (cmd == CMD_CFG_RD || cmd == CMD_CFG_WR);
    done = s_r.pst == P_DATA && !s_r.trdy_n && !bus.irdy_n;
    s_nxt.frame_prev = bus.frame_n;

    // ISA port: strobes count only while selected and in ISA mode
    s_nxt.wr_prev = bus.host_write_strobe_n;
    if (!pci_mode && !bus.port_select_n && !bus.host_write_strobe_n && s_r.wr_prev) begin
      if (bus.host_offset_address == REG_INT_STATUS) begin
        s_nxt.regs[REG_INT_STATUS] = s_r.regs[REG_INT_STATUS] & ~isa_din;
      end else begin
        s_nxt.regs[bus.host_offset_address] = isa_din;
      end
    end
    s_nxt.isa_oe = !pci_mode && !bus.port_select_n && !bus.host_read_strobe_n;
    s_nxt.isa_dout = read_reg(s_r, bus.host_offset_address);

    // PCI target sequencing
    unique case (s_r.pst)
      P_IDLE: begin
        s_nxt.ctl_oe = 1'b0;
        if (addr_phase && (hit_io || hit_cfg)) begin
          s_nxt.pst = P_DATA;
          s_nxt.is_write = cmd[0];
          s_nxt.is_cfg = hit_cfg;
          s_nxt.dw = bus.ad[7:2];
          s_nxt.ctl_oe = 1'b1;
          s_nxt.devsel_n = 1'b0;
        end
      end
      P_DATA: begin
        if (s_r.trdy_n) begin
          s_nxt.trdy_n = 1'b0;
          // A master still holding FRAME# wants a burst; disconnect with the first word
          s_nxt.stop_n = bus.frame_n;
          s_nxt.ad_oe = !s_r.is_write;
          if (s_r.is_cfg) begin
            s_nxt.ad_o = s_r.dw == CFG_CMDSTAT_DW ? s_r.cmdstat : (s_r.dw == CFG_ID_DW ? ID_WORD : 32'h0000_0000);
          end else begin
            s_nxt.ad_o = {24'h00_0000, read_reg(s_r, s_r.dw[2:0])};
          end
        end else if (done) begin
          s_nxt.trdy_n = 1'b1;
          s_nxt.ad_oe = 1'b0;
          if (s_r.is_write) begin
            s_nxt.data_par = ^{bus.ad, bus.cbe_n};
            if (s_r.is_cfg) begin
              if (s_r.dw == CFG_CMDSTAT_DW) begin
                for (int b = 0; b < 4; b++) begin
                  if (!bus.cbe_n[b]) s_nxt.cmdstat[b*8 +: 8] = bus.ad[b*8 +: 8];
                end
              end
            end else if (!bus.cbe_n[0]) begin
              if (s_r.dw[2:0] == REG_INT_STATUS) begin
                s_nxt.regs[REG_INT_STATUS] = s_r.regs[REG_INT_STATUS] & ~bus.ad[7:0];
              end else begin
                s_nxt.regs[s_r.dw[2:0]] = bus.ad[7:0];
              end
            end
          end
          if (bus.frame_n) begin
            s_nxt.pst = P_TURN;
            s_nxt.devsel_n = 1'b1;
            s_nxt.stop_n = 1'b1;
          end else begin
            s_nxt.pst = P_DRAIN;
            s_nxt.stop_n = 1'b0;
          end
        end
      end
      P_DRAIN: begin
        if (bus.frame_n) begin
          s_nxt.pst = P_TURN;
          s_nxt.devsel_n = 1'b1;
          s_nxt.stop_n = 1'b1;
        end
      end
      P_TURN: begin
        // Lines were driven high for one cycle before release
        s_nxt.ctl_oe = 1'b0;
        s_nxt.pst = P_IDLE;
      end
    endcase
    s_nxt.data_chk = done && s_r.is_write;

    // Parity: drive one clock after read data, check one clock after address and write data
    s_nxt.par_o = ^{s_r.ad_o, bus.cbe_n};
    s_nxt.par_oe = s_r.ad_oe;
    s_nxt.addr_chk = addr_phase;
    s_nxt.addr_par = ^{bus.ad, bus.cbe_n};
    s_nxt.serr_oe = s_r.addr_chk && (s_r.addr_par != bus.par) && s_r.cmdstat[SERR_EN_BIT];
    s_nxt.perr_n = !(s_r.data_chk && (s_r.data_par != bus.par));
    s_nxt.perr_oe = s_r.data_chk || !s_r.perr_n;

    // New events win over a same-cycle clear
    s_nxt.regs[REG_INT_STATUS] = s_nxt.regs[REG_INT_STATUS] | event_set;
    s_nxt.pend = |(s_r.regs[REG_INT_STATUS] & ~s_r.regs[REG_INT_MASK]);
    s_nxt.irq = !pci_mode && s_nxt.pend;
    s_nxt.int_n = !(pci_mode && s_nxt.pend);
    s_nxt.pme_n = !pme_request;
    s_nxt.power_off = power_off_request;
    if (!pci_mode) begin
      s_nxt.pst = P_IDLE;
      s_nxt.ctl_oe = 1'b0;
      s_nxt.ad_oe = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.int_n <= 1'b1;
      s_r.pme_n <= 1'b1;
      s_r.wr_prev <= 1'b1;
      s_r.frame_prev <= 1'b1;
      s_r.trdy_n <= 1'b1;
      s_r.devsel_n <= 1'b1;
      s_r.stop_n <= 1'b1;
      s_r.perr_n <= 1'b1;
      s_r.cmdstat <= CMDSTAT_RST;
      s_r.regs <= {8{REG_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.isa_d_data = s_r.isa_dout;
  assign bus.isa_d_oe = s_r.isa_oe;
  assign bus.irq = s_r.irq;
  assign bus.ad_d = s_r.ad_o;
  assign bus.ad_d_oe = s_r.ad_oe;
  assign bus.par_d = s_r.par_o;
  assign bus.par_d_oe = s_r.par_oe;
  assign bus.trdy_d_n = s_r.trdy_n;
  assign bus.devsel_d_n = s_r.devsel_n;
  assign bus.stop_d_n = s_r.stop_n;
  assign bus.ctl_d_oe = s_r.ctl_oe;
  assign bus.perr_d_n = s_r.perr_n;
  assign bus.perr_d_oe = s_r.perr_oe;
  assign bus.serr_d_oe = s_r.serr_oe;
  assign bus.int_n = s_r.int_n;
  assign bus.pme_n = s_r.pme_n;
  assign power_off_out = s_r.power_off;
  assign int_pending = s_r.pend;
endmodule // mhbi_dev

// file: rtl/mhbi_host.sv
// Host end: ISA-style I/O cycles and PCI single-phase master
`timescale 1ns/1ps
module mhbi_host (
  input wire logic clock,
  input wire logic rst_b,
  mhbi_if.host_mp bus,
  input wire logic req,
  input wire logic req_pci,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_cmd,
  input wire logic [3:0] req_be_n,
  input wire logic [31:0] req_wdata,
  output logic busy,
  output logic done,
  output logic aborted,
  output logic [31:0] rdata,
  output logic irq_seen,
  output logic int_seen,
  output logic err_seen,
  output logic pme_seen
);
  import mhbi_pkg::*;

  typedef enum logic [2:0] {H_IDLE = 3'b000, H_ISA = 3'b001, H_ADDR = 3'b010, H_DATA = 3'b011,
    H_TURN = 3'b100} mhbi_hst_t;

  typedef struct packed {
    mhbi_hst_t st;
    logic [7:0] cnt;
    logic write;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] be_n;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
    logic aborted;
    logic sel_n, wr_n, rd_n, isa_oe;
    logic frame_n, irdy_n, idsel;
    logic [3:0] cbe_n;
    logic [31:0] ad;
    logic ad_oe;
    logic par;
    logic par_oe;
    logic irq, int_a, err, pme;
    logic busy;
  } mhbi_host_t;

  mhbi_host_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.cnt = s_r.cnt + 8'h01;
    // Address phase parity and write data parity follow one clock later
    s_nxt.par = ^{s_r.ad, s_r.cbe_n};
    s_nxt.par_oe = s_r.ad_oe;
    unique case (s_r.st)
      H_IDLE: begin
        s_nxt.cnt = 8'h00;
        if (req) begin
          s_nxt.write = req_write;
          s_nxt.addr = req_addr;
          s_nxt.cmd = req_cmd;
          s_nxt.be_n = req_be_n;
          s_nxt.wdata = req_wdata;
          s_nxt.aborted = 1'b0;
          if (req_pci) begin
            s_nxt.st = H_ADDR;
            s_nxt.frame_n = 1'b0;
            s_nxt.cbe_n = req_cmd;
            s_nxt.ad = req_addr;
            s_nxt.ad_oe = 1'b1;
            s_nxt.idsel = req_cmd == CMD_CFG_RD || req_cmd == CMD_CFG_WR;
          end else begin
            s_nxt.st = H_ISA;
            s_nxt.sel_n = 1'b0;
            s_nxt.wr_n = !req_write;
            s_nxt.rd_n = req_write;
            s_nxt.isa_oe = req_write;
          end
        end
      end
      H_ISA: begin
        if (s_r.cnt == 8'(ISA_STROBE_CYC - 1)) begin
          s_nxt.rdata = {24'h00_0000, bus.host_data_high_nibble, bus.host_data_low_nibble};
          s_nxt.sel_n = 1'b1;
          s_nxt.wr_n = 1'b1;
          s_nxt.rd_n = 1'b1;
          s_nxt.isa_oe = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.st = H_IDLE;
        end
      end
      H_ADDR: begin
        s_nxt.st = H_DATA;
        s_nxt.cnt = 8'h00;
        s_nxt.frame_n = 1'b1;
        s_nxt.irdy_n = 1'b0;
        s_nxt.idsel = 1'b0;
        s_nxt.cbe_n = s_r.be_n;
        s_nxt.ad = s_r.wdata;
        s_nxt.ad_oe = s_r.write;
      end
      H_DATA: begin
        if ((!bus.trdy_n && !bus.irdy_n) || !bus.stop_n ||
            (bus.devsel_n && s_r.cnt == 8'(MASTER_ABORT_CYC - 1))) begin
          s_nxt.rdata = bus.ad;
          s_nxt.aborted = bus.trdy_n;
          s_nxt.st = H_TURN;
          s_nxt.irdy_n = 1'b1;
          s_nxt.ad_oe = 1'b0;
        end
      end
      H_TURN: begin
        s_nxt.done = 1'b1;
        s_nxt.st = H_IDLE;
      end
      default: begin
        s_nxt.st = H_IDLE;
      end
    endcase
    // Registered copy keeps the busy output straight off a flop
    s_nxt.busy = s_nxt.st != H_IDLE;
    s_nxt.irq = bus.irq;
    s_nxt.int_a = !bus.int_n;
    s_nxt.err = !bus.perr_n || !bus.serr_n;
    s_nxt.pme = !bus.pme_n;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.sel_n <= 1'b1;
      s_r.wr_n <= 1'b1;
      s_r.rd_n <= 1'b1;
      s_r.frame_n <= 1'b1;
      s_r.irdy_n <= 1'b1;
      s_r.cbe_n <= 4'hF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.isa_h_data = s_r.wdata[7:0];
  assign bus.isa_h_oe = s_r.isa_oe;
  assign bus.host_offset_address = s_r.addr[2:0];
  assign bus.host_write_strobe_n = s_r.wr_n;
  assign bus.host_read_strobe_n = s_r.rd_n;
  assign bus.port_select_n = s_r.sel_n;
  assign bus.ad_h = s_r.ad;
  assign bus.ad_h_oe = s_r.ad_oe;
  assign bus.cbe_n = s_r.cbe_n;
  assign bus.par_h = s_r.par;
  assign bus.par_h_oe = s_r.par_oe;
  assign bus.frame_n = s_r.frame_n;
  assign bus.irdy_n = s_r.irdy_n;
  assign bus.idsel = s_r.idsel;
  assign busy = s_r.busy;
  assign done = s_r.done;
  assign aborted = s_r.aborted;
  assign rdata = s_r.rdata;
  assign irq_seen = s_r.irq;
  assign int_seen = s_r.int_a;
  assign err_seen = s_r.err;
  assign pme_seen = s_r.pme;
endmodule // mhbi_host

// file: dv/mhbi_checker.sv
// Protocol assertions on the carrier joining device and host ends
`timescale 1ns/1ps
module mhbi_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic isa_d_oe,
  input wire logic port_select_n,
  input wire logic host_read_strobe_n,
  input wire logic irq,
  input wire logic int_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic idsel,
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic perr_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_rd; !port_select_n && !host_read_strobe_n; endsequence
  sequence s_addr; frame_n ##1 !frame_n; endsequence
  sequence s_done; !trdy_n && !irdy_n; endsequence
  property p_isa_oe_cause; isa_d_oe |-> $past(!port_select_n && !host_read_strobe_n); endproperty
  a_isa_oe_cause: assert property (p_isa_oe_cause) else $error("data bus driven outside a read");
  property p_isa_answer; s_rd |=> isa_d_oe; endproperty
  a_isa_answer: assert property (p_isa_answer) else $error("read data not driven");
  property p_devsel_addr; $fell(devsel_n) |-> !$past(frame_n) && $past(frame_n, 2); endproperty
  a_devsel_addr: assert property (p_devsel_addr) else $error("devsel not one cycle after address");
  property p_cfg_idsel; $fell(devsel_n) && $past(cbe_n[3]) |-> $past(idsel); endproperty
  a_cfg_idsel: assert property (p_cfg_idsel) else $error("config claim without idsel");
  property p_trdy_turn; $fell(devsel_n) |=> !trdy_n; endproperty
  a_trdy_turn: assert property (p_trdy_turn) else $error("trdy late after devsel");
  property p_trdy_one; s_done |=> trdy_n; endproperty
  a_trdy_one: assert property (p_trdy_one) else $error("trdy held past completion");
  property p_par_addr; s_addr |=> par == ^{$past(ad), $past(cbe_n)}; endproperty
  a_par_addr: assert property (p_par_addr) else $error("address parity not even");
  property p_par_data; s_done |=> par == ^{$past(ad), $past(cbe_n)}; endproperty
  a_par_data: assert property (p_par_data) else $error("data parity not even");
  property p_irq_int; irq |-> int_n; endproperty
  a_irq_int: assert property (p_irq_int) else $error("both interrupt outputs active");
  property p_no_perr; s_done |-> ##2 perr_n; endproperty
  a_no_perr: assert property (p_no_perr) else $error("parity error on clean data");
endmodule // mhbi_checker

// file: dv/tb.sv
// Self-checking bench: host end against device end, plus a fault-injecting bus
`timescale 1ns/1ps
module tb;
  import mhbi_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h00A5_005A; // Arbitrary identity value
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic bus_type_select = 1'b0;
  logic [7:0] event_set = 8'h00;
  logic pme_request = 1'b0;
  logic power_off_request = 1'b0;
  logic req = 1'b0;
  logic req_pci = 1'b0;
  logic req_write = 1'b0;
  logic [31:0] req_addr = 32'h0000_0000;
  logic [3:0] req_cmd = 4'h0;
  logic [3:0] req_be_n = 4'hF;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic busy, done, aborted, irq_seen, int_seen, err_seen, pme_seen, power_off_out, int_pending, dsel;
  logic [31:0] rdata;
  int n_errors = 0;
  int total_checks = 0;
  mhbi_if mif();
  mhbi_if bf();
  always #2.5 clock = ~clock;
  mhbi_dev #(.ID_WORD(ID_VAL)) mhbi_dev_i (.clock, .rst_b, .bus(mif.dev_mp), .bus_type_select, .event_set,
    .pme_request, .power_off_request, .power_off_out, .int_pending);
  // Second device faces the bench directly so bad parity can be injected
  mhbi_dev #(.ID_WORD(ID_VAL)) mhbi_dev_i2 (.clock, .rst_b, .bus(bf.dev_mp), .bus_type_select(1'b1),
    .event_set, .pme_request, .power_off_request, .power_off_out(), .int_pending());
  mhbi_host mhbi_host_i (.clock, .rst_b, .bus(mif.host_mp), .req, .req_pci, .req_write, .req_addr, .req_cmd,
    .req_be_n, .req_wdata, .busy, .done, .aborted, .rdata, .irq_seen, .int_seen, .err_seen, .pme_seen);
  mhbi_checker mhbi_checker_i (.clock, .rst_b, .isa_d_oe(mif.isa_d_oe), .port_select_n(mif.port_select_n),
    .host_read_strobe_n(mif.host_read_strobe_n), .irq(mif.irq), .int_n(mif.int_n), .ad(mif.ad),
    .cbe_n(mif.cbe_n), .par(mif.par), .frame_n(mif.frame_n), .irdy_n(mif.irdy_n), .idsel(mif.idsel),
    .trdy_n(mif.trdy_n), .devsel_n(mif.devsel_n), .perr_n(mif.perr_n));

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // One host request, waited on under a bound
  task automatic xfer(input logic pci, input logic wr, input logic [31:0] a, input logic [3:0] cmd,
    input logic [3:0] be, input logic [31:0] d);
    int k;
    req_pci = pci;
    req_write = wr;
    req_addr = a;
    req_cmd = cmd;
    req_be_n = be;
    req_wdata = d;
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    chk("busy", 1, busy);
    k = 0;
    while (done !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    chk("done", 1, done);
    chk("busy idle", 0, busy);
  endtask

  task automatic pulse(input logic [7:0] v);
    event_set = v;
    @(negedge clock);
    event_set = 8'h00;
    repeat (3) @(negedge clock);
  endtask

  // Single-phase cycle on the fault bus; fl 1 spoils address parity, fl 2 data parity, fl 3 holds FRAME#
  task automatic bcyc(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] d, input logic sel,
    input int fl);
    int k;
    bf.frame_n = 1'b0;
    bf.ad_h_oe = 1'b1;
    bf.ad_h = a;
    bf.cbe_n = cmd;
    bf.idsel = sel;
    @(negedge clock);
    bf.frame_n = (fl != 3);
    bf.irdy_n = 1'b0;
    bf.par_h_oe = 1'b1;
    bf.par_h = ^{a, cmd} ^ (fl == 1);
    bf.cbe_n = 4'h0;
    bf.ad_h = d;
    bf.ad_h_oe = cmd[0];
    bf.idsel = 1'b0;
    if (fl == 1) chk("serr_n early", 1, bf.serr_n);
    @(negedge clock);
    bf.par_h_oe = 1'b0;
    dsel = bf.devsel_n;
    if (fl == 1) chk("serr_n", 0, bf.serr_n);
    chk("stop_n", fl != 3, bf.stop_n);
    if (fl == 3) chk("burst data", d, bf.ad);
    k = 0;
    while (bf.trdy_n !== 1'b0 && k < 6) begin
      @(negedge clock);
      k++;
    end
    @(negedge clock);
    if (fl == 3) chk("stop_n held", 0, bf.stop_n);
    bf.frame_n = 1'b1;
    bf.irdy_n = 1'b1;
    bf.ad_h_oe = 1'b0;
    bf.par_h = ^d ^ (fl == 2);
    bf.par_h_oe = cmd[0];
    @(negedge clock);
    bf.par_h_oe = 1'b0;
    if (fl == 2) chk("perr_n", 0, bf.perr_n);
    repeat (2) @(negedge clock);
  endtask

  initial begin
    bf.isa_h_data = 8'h00;
    bf.isa_h_oe = 1'b0;
    bf.host_offset_address = 3'h0;
    bf.host_write_strobe_n = 1'b1;
    bf.host_read_strobe_n = 1'b1;
    bf.port_select_n = 1'b1;
    bf.ad_h = 32'h0000_0000;
    bf.ad_h_oe = 1'b0;
    bf.cbe_n = 4'hF;
    bf.par_h = 1'b0;
    bf.par_h_oe = 1'b0;
    bf.frame_n = 1'b1;
    bf.irdy_n = 1'b1;
    bf.idsel = 1'b0;
  end

  initial begin
    #25000;
    n_errors++;
    $display("unexpected watchdog: expected end seen timeout");
    finish_test;
  end

  initial begin
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    for (int i = 0; i < 5; i++) xfer(0, 1, i, 4'h0, 4'hE, 32'h0000_0030 + i);
    for (int i = 0; i < 5; i++) begin
      xfer(0, 0, i, 4'h0, 4'hE, 32'h0000_0000);
      chk("isa reg", 32'h0000_0030 + i, rdata[7:0]);
    end
    pulse(8'h04);
    chk("irq", 1, mif.irq);
    chk("int_n isa", 1, mif.int_n);
    chk("irq_seen", 1, irq_seen);
    xfer(0, 0, REG_INT_STATUS, 4'h0, 4'hE, 32'h0000_0000);
    chk("status", 32'h0000_0004, rdata[7:0]);
    xfer(0, 1, REG_INT_MASK, 4'h0, 4'hE, 32'h0000_0004);
    repeat (3) @(negedge clock);
    chk("irq masked", 0, mif.irq);
    chk("pending masked", 0, int_pending);
    xfer(0, 1, REG_INT_MASK, 4'h0, 4'hE, 32'h0000_0000);
    xfer(0, 1, REG_INT_STATUS, 4'h0, 4'hE, 32'h0000_0004);
    repeat (3) @(negedge clock);
    chk("irq cleared", 0, mif.irq);
    xfer(1, 0, PCI_BASE_DEF, CMD_MEM_RD, 4'hE, 32'h0000_0000);
    chk("pci in isa mode", 1, aborted);
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    xfer(0, 0, 1, 4'h0, 4'hE, 32'h0000_0000);
    chk("reg after reset", REG_RST, rdata[7:0]);
    bus_type_select = 1'b1;
    for (int i = 0; i < 4; i++) xfer(1, 1, PCI_BASE_DEF + 4 * i, i[0] ? CMD_IO_WR : CMD_MEM_WR, 4'hE,
      32'h0000_0050 + i);
    for (int i = 0; i < 4; i++) begin
      xfer(1, 0, PCI_BASE_DEF + 4 * i, i[0] ? CMD_MEM_RD : CMD_IO_RD, 4'hE, 32'h0000_0000);
      chk("pci reg", 32'h0000_0050 + i, rdata[7:0]);
      chk("pci hit", 0, aborted);
    end
    xfer(1, 1, PCI_BASE_DEF, CMD_MEM_WR, 4'h1, 32'h0000_00EE);
    xfer(1, 0, PCI_BASE_DEF, CMD_MEM_RD, 4'hE, 32'h0000_0000);
    chk("lane off", 32'h0000_0050, rdata[7:0]);
    xfer(1, 0, PCI_BASE_DEF + 32'h0000_0020, CMD_MEM_RD, 4'hE, 32'h0000_0000);
    chk("miss", 1, aborted);
    xfer(1, 0, 32'h0000_0000, CMD_CFG_RD, 4'h0, 32'h0000_0000);
    chk("id", ID_VAL, rdata);
    xfer(1, 1, 32'h0000_0004, CMD_CFG_WR, 4'h7, 32'h8000_0000);
    xfer(1, 1, 32'h0000_0004, CMD_CFG_WR, 4'hF, 32'h0000_0000);
    xfer(1, 0, 32'h0000_0004, CMD_CFG_RD, 4'h0, 32'h0000_0000);
    chk("cmdstat", 1, rdata[SERR_EN_BIT]);
    pulse(8'h10);
    chk("int_n", 0, mif.int_n);
    chk("irq pci", 0, mif.irq);
    chk("int_seen", 1, int_seen);
    xfer(1, 1, PCI_BASE_DEF + 4 * REG_INT_MASK, CMD_MEM_WR, 4'hE, 32'h0000_0010);
    repeat (3) @(negedge clock);
    chk("int_n masked", 1, mif.int_n);
    pme_request = 1'b1;
    power_off_request = 1'b1;
    repeat (3) @(negedge clock);
    chk("pme_n", 0, mif.pme_n);
    chk("pme_seen", 1, pme_seen);
    chk("power_off", 1, power_off_out);
    chk("err_seen", 0, err_seen);
    bcyc(CMD_CFG_WR, 32'h0000_0004, 32'h8000_0000, 1'b1, 0);
    chk("cfg claim", 0, dsel);
    bcyc(CMD_CFG_RD, 32'h0000_0000, 32'h0000_0000, 1'b0, 0);
    chk("cfg no idsel", 1, dsel);
    bcyc(CMD_MEM_WR, PCI_BASE_DEF, 32'h0000_0011, 1'b0, 1);
    bcyc(CMD_MEM_WR, PCI_BASE_DEF, 32'h0000_0022, 1'b0, 2);
    bcyc(CMD_MEM_RD, PCI_BASE_DEF, 32'h0000_0022, 1'b0, 3);
    finish_test;
  end
endmodule // tb
